// >>> design/gimnc_top.sv
// guarded integer multiply, negate and not-equal compare datapath
`include "gimnc_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module gimnc_top #(
  // operand and result width
  parameter int DATA_W = `GIMNC_DATA_W,
  // immediate field width
  parameter int IMM_W = `GIMNC_IMM_W,
  // destination index width
  parameter int DEST_W = 7,
  // multiply pipe depth, one stage per cycle of latency
  parameter int MUL_LAT = `GIMNC_MUL_LAT
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  // issue
  input wire logic issue_valid,
  input wire gimnc_pkg::gimnc_op_e issue_op,
  // operands
  input wire logic [DATA_W-1:0] source_operand_a,
  input wire logic [DATA_W-1:0] source_operand_b,
  input wire logic [IMM_W-1:0] issue_imm,
  // guard
  input wire logic guard_present,
  input wire logic [DATA_W-1:0] guard_value,
  // destination
  input wire logic [DEST_W-1:0] issue_dest,
  // alu writeback
  output logic alu_wr_en,
  output logic [DEST_W-1:0] alu_wr_dest,
  output logic [DATA_W-1:0] alu_wr_data,
  // multiplier writeback
  output logic mul_wr_en,
  output logic [DEST_W-1:0] mul_wr_dest,
  output logic [DATA_W-1:0] mul_wr_data
);
  // ----------------------------------------
  // overview
  // ----------------------------------------
  // two independent pipes: one alu stage and MUL_LAT multiply stages
  // a refused or unknown issue enters as a bubble, so no write follows it
  // ce low holds every stage; issues seen then are dropped, not queued
  // a write request stands one cycle, or longer while ce is low
  // outputs are write requests only; the register file lives outside
  // no hazard check here: the issue logic must respect the latencies
  // both ports may fire in one cycle, to different or equal destinations
  // an equal destination in one cycle is for the register file to order

  // ----------------------------------------
  // issue decode
  // ----------------------------------------
  // purely combinational, taken at the clock edge
  wire logic guard_bit;
  wire logic guard_ok;
  wire logic go;
  wire logic is_mul_lo;
  wire logic is_mul_hi;
  wire logic is_mul;
  wire logic is_neg;
  wire logic is_cne;
  wire logic is_cnei;
  wire logic is_alu;
  wire logic alu_go;
  wire logic mul_go;

  // only bit 0 of the guard word matters, the rest is ignored on purpose
  assign guard_bit = guard_value[`GIMNC_GUARD_BIT];
  // guard gating
  // no guard supplied means the write always goes ahead
  assign guard_ok = !guard_present || guard_bit;
  assign go = issue_valid && guard_ok;

  // one flag per operation code
  assign is_mul_lo = issue_op == gimnc_pkg::OP_MUL_LO;
  assign is_mul_hi = issue_op == gimnc_pkg::OP_MUL_HI;
  assign is_neg = issue_op == gimnc_pkg::OP_NEG;
  assign is_cne = issue_op == gimnc_pkg::OP_CMP_NE;
  assign is_cnei = issue_op == gimnc_pkg::OP_CMP_NE_IMM;

  // unit steering; unused codes reach neither unit and write nothing
  assign is_mul = is_mul_lo || is_mul_hi;
  assign is_alu = is_neg || is_cne || is_cnei;
  // refused issue never enters a pipe
  assign alu_go = go && is_alu;
  assign mul_go = go && is_mul;

  // ----------------------------------------
  // operand views
  // ----------------------------------------
  // sign bits named once, shared by multiplier and immediate
  wire logic sign_a;
  wire logic sign_b;
  wire logic sign_imm;
  wire logic [DATA_W-1:0] zero_register;
  wire logic [DATA_W-1:0] imm_ext;
  wire logic [DATA_W-IMM_W-1:0] imm_fill;

  assign sign_a = source_operand_a[DATA_W-1];
  assign sign_b = source_operand_b[DATA_W-1];
  assign sign_imm = issue_imm[IMM_W-1];
  // constant zero source, never written
  assign zero_register = `GIMNC_ZERO_WORD;
  // sign-extend immediate
  // covers -64 to 63; a zero fill would turn -1 into 127
  assign imm_fill = {(DATA_W-IMM_W){sign_imm}};
  assign imm_ext = {imm_fill, issue_imm};

  // ----------------------------------------
  // alu operations
  // ----------------------------------------
  // every alu result is ready in the issue cycle and registered once
  wire logic [DATA_W-1:0] neg_res;
  wire logic cne_hit;
  wire logic cnei_hit;
  wire logic [DATA_W-1:0] cne_res;
  wire logic [DATA_W-1:0] cnei_res;
  wire logic [DATA_W-1:0] alu_res;

  // subtract from zero, wraps at min
  // most negative input comes back unchanged, no overflow flag
  assign neg_res = zero_register - source_operand_a;
  assign cne_hit = source_operand_a != source_operand_b;
  assign cne_res = cne_hit ? `GIMNC_TRUE_WORD : `GIMNC_FALSE_WORD;
  // immediate not-equal
  // equality is sign-blind once both sides have the same width
  assign cnei_hit = source_operand_a != imm_ext;
  assign cnei_res = cnei_hit ? `GIMNC_TRUE_WORD : `GIMNC_FALSE_WORD;
  // the immediate compare takes the last arm of the select
  assign alu_res = is_neg ? neg_res : (is_cne ? cne_res : cnei_res);

  // ----------------------------------------
  // multiplier
  // ----------------------------------------
  wire logic [2*DATA_W-1:0] op_a_ext;
  wire logic [2*DATA_W-1:0] op_b_ext;
  wire logic signed [2*DATA_W-1:0] prod;
  wire logic [DATA_W-1:0] prod_lo;
  wire logic [DATA_W-1:0] prod_hi;
  wire logic [DATA_W-1:0] mul_res;

  assign op_a_ext = {{DATA_W{sign_a}}, source_operand_a};
  assign op_b_ext = {{DATA_W{sign_b}}, source_operand_b};
  // a 2n-bit product of sign-extended words is exact, no carry is lost
  assign prod = $signed(op_a_ext) * $signed(op_b_ext);
  assign prod_lo = prod[DATA_W-1:0];
  assign prod_hi = prod[2*DATA_W-1:DATA_W];
  // low word truncated, no overflow flag
  // only the word asked for is kept, the other half is dropped
  assign mul_res = is_mul_hi ? prod_hi : prod_lo;

  // ----------------------------------------
  // alu stage, one cycle
  // ----------------------------------------
  // alu latency one
  // one flop is the whole alu latency; no bypass is offered
  gimnc_stage #(.DATA_W(DATA_W), .DEST_W(DEST_W)) u_alu_stage (
    .clk(clk),
    .arst_n(arst_n),
    .ce(ce),
    .in_valid(alu_go),
    .in_dest(issue_dest),
    .in_data(alu_res),
    .out_valid(alu_wr_en),
    .out_dest(alu_wr_dest),
    .out_data(alu_wr_data)
  );

  // ----------------------------------------
  // multiplier pipe, MUL_LAT cycles
  // ----------------------------------------
  // product computed at issue, carried through stages; retiming left to synthesis
  // tap 0 is the issue cycle, tap MUL_LAT the write request
  logic [MUL_LAT:0] pv;
  logic [DEST_W-1:0] pd [MUL_LAT+1];
  logic [DATA_W-1:0] pr [MUL_LAT+1];
  assign pv[0] = mul_go;
  assign pd[0] = issue_dest;
  assign pr[0] = mul_res;
  for (genvar i = 0; i < MUL_LAT; i++) begin : g_mul
    gimnc_stage #(.DATA_W(DATA_W), .DEST_W(DEST_W)) u_stage (
      .clk(clk),
      .arst_n(arst_n),
      .ce(ce),
      .in_valid(pv[i]),
      .in_dest(pd[i]),
      .in_data(pr[i]),
      .out_valid(pv[i+1]),
      .out_dest(pd[i+1]),
      .out_data(pr[i+1])
    );
  end

  // ----------------------------------------
  // multiplier writeback
  // ----------------------------------------
  // result leaves the last stage
  assign mul_wr_en = pv[MUL_LAT];
  assign mul_wr_dest = pd[MUL_LAT];
  assign mul_wr_data = pr[MUL_LAT];
endmodule // gimnc_top
`default_nettype wire

// >>> design/gimnc_defines.svh
// constants for the guarded multiply, negate and compare datapath
`ifndef GIMNC_DEFINES_SVH
`define GIMNC_DEFINES_SVH

`define GIMNC_DATA_W 32
`define GIMNC_IMM_W 7
`define GIMNC_MUL_LAT 3
`define GIMNC_ALU_LAT 1
`define GIMNC_GUARD_BIT 0
`define GIMNC_ZERO_WORD 32'h0000_0000
`define GIMNC_TRUE_WORD 32'h0000_0001
`define GIMNC_FALSE_WORD 32'h0000_0000

`endif

// >>> design/gimnc_pkg.sv
// types for the guarded multiply, negate and compare datapath
package gimnc_pkg;
  typedef enum logic [2:0] {
    OP_MUL_LO,
    OP_MUL_HI,
    OP_NEG,
    OP_CMP_NE,
    OP_CMP_NE_IMM
  } gimnc_op_e;
endpackage

// >>> design/gimnc_stage.sv
// one pipeline stage carrying a write request
`timescale 1ns/1ps
`default_nettype none
module gimnc_stage #(
  parameter int DATA_W = 32,
  parameter int DEST_W = 7
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  // stage input
  input wire logic in_valid,
  input wire logic [DEST_W-1:0] in_dest,
  input wire logic [DATA_W-1:0] in_data,
  // stage output
  output logic out_valid,
  output logic [DEST_W-1:0] out_dest,
  output logic [DATA_W-1:0] out_data
);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      out_valid <= 1'b0;
      out_dest <= '0;
      out_data <= '0;
    end else if (ce) begin
      out_valid <= in_valid;
      out_dest <= in_dest;
      out_data <= in_data;
    end
  end
endmodule // gimnc_stage
`default_nettype wire

// >>> testbench/gimnc_assertions.sv
// write port assertions for the guarded datapath
`timescale 1ns/1ps
`default_nettype none
module gimnc_assertions (
  input wire logic clk, arst_n, ce, issue_valid, guard_present, alu_wr_en, mul_wr_en,
  input wire gimnc_pkg::gimnc_op_e issue_op,
  input wire logic [31:0] source_operand_a, source_operand_b, guard_value, alu_wr_data, mul_wr_data,
  input wire logic [6:0] issue_imm, issue_dest, alu_wr_dest, mul_wr_dest
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  wire logic [31:0] a = source_operand_a, b = source_operand_b, ad = alu_wr_data, md = mul_wr_data;
  wire logic [2:0] op = issue_op;
  wire logic tk = issue_valid & ce & (!guard_present | guard_value[0]);
  wire logic ta = tk & op > 3'h1, tm = tk & op < 3'h2;
  wire logic signed [63:0] p = $signed(a) * $signed(b);
  wire logic ne = a != b, ni = a != {{25{issue_imm[6]}}, issue_imm};
  sequence mo; ##3 mul_wr_en; endsequence
  sequence ao; ##1 alu_wr_en; endsequence
  lo_word_a: assert property (tk && op == 3'h0 |-> mo ##0 md == $past(p[31:0], 3)) else $error("low word");
  hi_word_a: assert property (tk && op == 3'h1 |-> mo ##0 md == $past(p[63:32], 3)) else $error("high word");
  neg_value_a: assert property (tk && op == 3'h2 |-> ao ##0 ad == 32'h0000_0000 - $past(a)) else $error("negate");
  cmp_reg_a: assert property (tk && op == 3'h3 |-> ao ##0 ad == {31'h0, $past(ne)}) else $error("reg compare");
  cmp_imm_a: assert property (tk && op == 3'h4 |-> ao ##0 ad == {31'h0, $past(ni)}) else $error("imm compare");
  guard_off_a: assert property (issue_valid && !tk |=> !alu_wr_en ##2 !mul_wr_en) else $error("false guard");
  alu_src_a: assert property (alu_wr_en |-> $past(ta) && alu_wr_dest == $past(issue_dest)) else $error("alu write");
  mul_src_a: assert property (mul_wr_en |-> $past(tm, 3) && mul_wr_dest == $past(issue_dest, 3))
    else $error("mul write");
endmodule // gimnc_assertions
`default_nettype wire

// >>> testbench/gimnc_rf_model.sv
// register file model behind the write ports
`timescale 1ns/1ps
`default_nettype none
module gimnc_rf_model (
  input wire logic clk, alu_wr_en, mul_wr_en,
  input wire logic [6:0] alu_wr_dest, mul_wr_dest,
  input wire logic [31:0] alu_wr_data, mul_wr_data
);
  logic [31:0] mem [128] = '{default: 32'h0000_0000};
  always @(posedge clk) begin
    if (alu_wr_en) mem[alu_wr_dest] <= alu_wr_data;
    if (mul_wr_en) mem[mul_wr_dest] <= mul_wr_data;
  end
endmodule // gimnc_rf_model
`default_nettype wire

// >>> testbench/tb_top.sv
// self-checking bench for the guarded datapath
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 0, arst_n = 0, ce = 1, issue_valid = 0, guard_present = 0, alu_wr_en, mul_wr_en;
  gimnc_pkg::gimnc_op_e issue_op = gimnc_pkg::OP_NEG;
  logic [31:0] source_operand_a = 0, source_operand_b = 0, guard_value = 0, alu_wr_data, mul_wr_data;
  logic [6:0] issue_imm = 0, issue_dest = 0, alu_wr_dest, mul_wr_dest;
  logic [39:0] ea = 0, w;
  logic [119:0] em = 0;
  integer seed = 32'h0000_ec08, num_errors = 0, checked = 0, cyc = 0;
  gimnc_top uut (.*);
  gimnc_rf_model rf (.*);
  always #25 clk = ~clk;
  function automatic logic [39:0] want(logic [2:0] o, logic [31:0] a, b, logic [6:0] i);
    logic signed [63:0] p = $signed(a) * $signed(b);
    logic [31:0] r [5] = '{p[31:0], p[63:32], -a, 32'(a != b), 32'(a != {{25{i[6]}}, i})};
    return {ce & issue_valid & (!guard_present | guard_value[0]), issue_dest, r[o]};
  endfunction
  task automatic chk(logic [39:0] g, e);
    checked++;
    if (g[39] !== e[39] || e[39] && g !== e) begin
      num_errors++;
      $display("CHECK FAILED %0t wrong write", $time);
    end
  endtask
  task automatic wrap_up;
    if (num_errors == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic go(logic [2:0] o, logic [31:0] a, b, logic [6:0] i, logic [1:0] g);
    @(posedge clk);
    #5 issue_op = gimnc_pkg::gimnc_op_e'(o);
    {issue_valid, source_operand_a, source_operand_b, issue_imm, guard_present} = {1'b1, a, b, i, g[1]};
    {guard_value, issue_dest} = {31'($random(seed)), g[0], 7'($random(seed))};
  endtask
  // multiply results land two edges later than alu ones
  always @(posedge clk) begin
    w = want(issue_op, source_operand_a, source_operand_b, issue_imm);
    ea <= issue_op > 1 ? w : 40'h0;
    em <= {em[79:0], issue_op < 2 ? w : 40'h0};
    cyc <= cyc + 1;
    if (cyc > 2000) begin
      num_errors++;
      wrap_up();
    end
  end
  always @(negedge clk) if (arst_n) begin
    chk({alu_wr_en, alu_wr_dest, alu_wr_data}, ea);
    chk({mul_wr_en, mul_wr_dest, mul_wr_data}, em[119:80]);
  end
  initial begin
    repeat (3) @(posedge clk);
    #5 arst_n = 1;
    go(2, 32'h8000_0000, 0, 0, 3);
    go(1, 32'h0001_0000, 32'h0001_0000, 0, 0);
    go(0, 32'h7fff_ffff, 3, 0, 0);
    go(2, 32'h0000_0001, 0, 0, 2);
    go(4, 32'hffff_ffc0, 0, 7'h40, 0);
    repeat (500) go(3'({$random(seed)} % 5), $random(seed), $random(seed), 7'($random(seed)), 2'($random(seed)));
    @(posedge clk);
    #5 issue_valid = 0;
    repeat (4) @(posedge clk);
    // issues while ce is low must be dropped
    #5 ce = 0;
    go(2, 32'h0000_0005, 0, 0, 0);
    go(0, 32'h0000_0005, 5, 0, 0);
    @(posedge clk);
    #5 {ce, issue_valid} = 2'b10;
    repeat (5) @(posedge clk);
    wrap_up();
  end
endmodule // tb_top
bind gimnc_top gimnc_assertions chk_i (.*);
`default_nettype wire
